//--- hw/ett_consts.svh
// constants of the eight-bit timer counter unit
// assumes a 32-bit classic wishbone bus, byte addresses
`ifndef ETT_CONSTS_SVH
`define ETT_CONSTS_SVH
// register byte offsets
`define ETT_OFS_CNT 8'h00
`define ETT_OFS_CMPA 8'h04
`define ETT_OFS_CMPB 8'h08
`define ETT_OFS_CTLA 8'h0c
`define ETT_OFS_CTLB 8'h10
`define ETT_OFS_FLG 8'h14
`define ETT_OFS_MSK 8'h18
`define ETT_OFS_ASY 8'h1c
`define ETT_OFS_PWR 8'h20
// field positions
`define ETT_WM2_BIT 3
`define ETT_FLG_OVF 0
`define ETT_FLG_CA 1
`define ETT_FLG_CB 2
// reset values
`define ETT_RST_PWR 1'b1
`define ETT_RST_BYTE 8'h00
// count range ends
`define ETT_MAX 8'hff
`define ETT_BOTTOM 8'h00
// wave modes
`define ETT_WM_NORMAL 3'h0
`define ETT_WM_PCMAX 3'h1
`define ETT_WM_CTC 3'h2
`define ETT_WM_FASTMAX 3'h3
`define ETT_WM_PCA 3'h5
`define ETT_WM_FASTA 3'h7
// prescaler masks per clock select
`define ETT_PM_1 10'h000
`define ETT_PM_8 10'h007
`define ETT_PM_32 10'h01f
`define ETT_PM_64 10'h03f
`define ETT_PM_128 10'h07f
`define ETT_PM_256 10'h0ff
`define ETT_PM_1024 10'h3ff
`endif

//--- hw/ett_pkg.sv
// types of the eight-bit timer counter unit
// assumes ett_consts.svh for all numbers
package ett_pkg;
   typedef logic [2:0] ett_flag_t;

   typedef struct packed {
      logic [2:0] sh;
      logic q;
   } ett_sync_s;

   typedef struct packed {
      logic [9:0] cnt;
      logic tick;
   } ett_pre_s;

   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] cmp_a;
      logic [7:0] cmp_b;
      logic [2:0] wave;
      logic [2:0] cs;
      logic asy;
      logic pwr;
      ett_flag_t flg;
      ett_flag_t msk;
      logic down;
      logic block;
      logic xprev;
      logic ack;
      logic [7:0] dat;
      logic irq;
      logic match_a;
      logic match_b;
      logic top;
      logic bottom;
      logic xout;
   } ett_state_s;
endpackage

//--- hw/ett_sync3.sv
// three-stage synchroniser for a pin level
// assumes the pin is asynchronous to clk_i
`timescale 1ns/1ps
module ett_sync3 import ett_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // pin and synced level
   input wire logic pin_i,
   output logic lvl_o
);
   ett_sync_s s_ff;
   ett_sync_s nxt_s;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.sh = {s_ff.sh[1:0], pin_i};
      // output follows stage three only when stages two and three agree
      if (s_ff.sh[1] == s_ff.sh[2]) begin
         nxt_s.q = s_ff.sh[2];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign lvl_o = s_ff.q;
endmodule

//--- hw/ett_presc.sv
// ten-bit prescaler giving the timer tick
// assumes src_i is a one-cycle source pulse on clk_i
`timescale 1ns/1ps
`include "ett_consts.svh"
module ett_presc import ett_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // source and select
   input wire logic src_i,
   input wire logic [2:0] cs_i,
   // tick out
   output logic tick_o
);
   ett_pre_s p_ff;
   ett_pre_s nxt_p;
   logic [9:0] msk;

   always_comb begin
      unique case (cs_i)
         3'h2: msk = `ETT_PM_8;
         3'h3: msk = `ETT_PM_32;
         3'h4: msk = `ETT_PM_64;
         3'h5: msk = `ETT_PM_128;
         3'h6: msk = `ETT_PM_256;
         3'h7: msk = `ETT_PM_1024;
         default: msk = `ETT_PM_1;
      endcase
   end

   always_comb begin
      nxt_p = p_ff;
      nxt_p.tick = 1'b0;
      if (cs_i == 3'h0) begin
         nxt_p.cnt = 10'h000;
      end else if (src_i) begin
         nxt_p.cnt = p_ff.cnt + 10'h001;
         nxt_p.tick = (p_ff.cnt & msk) == msk;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         p_ff <= '0;
      end else begin
         p_ff <= nxt_p;
      end
   end

   assign tick_o = p_ff.tick;
endmodule

//--- hw/ett_timer.sv
// eight-bit timer counter with two compare registers
// assumes a classic wishbone master on clk_i, crystal pin asynchronous
`timescale 1ns/1ps
`include "ett_consts.svh"
// Overview of operation
// - counter and compares are eight bits
// - flags per request, each gated by mask
// - clock select zero holds counter idle
// - io clock default, crystal when selected
// - power-off bit set keeps timer disabled
// - zero is bottom, bottom signal asserted
// - all ones is the maximum value
// - top is max or compare a
// - each tick clears, increments or decrements
// - counter readable, writable while stopped
// - cpu counter write beats count
// - three-bit wave mode across two registers
// - compares checked, set flags, match out
// - overflow flag per mode, raises interrupt
// - mode zero counts up, overflows at wrap
// - mode two clears on compare a
// - flags cleared by service or write-one
// - counter write blocks next tick's match
module ett_timer import ett_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic ack_o,
   output logic [31:0] dat_o,
   // interrupt service acknowledge and request
   input wire logic [2:0] svc_i,
   output logic irq_o,
   // crystal pins
   input wire logic crystal_pin_in_i,
   output logic crystal_pin_out_o,
   // waveform generator side
   output logic match_a_o,
   output logic match_b_o,
   output logic top_o,
   output logic bottom_o
);
   ett_state_s s_ff;
   ett_state_s nxt_s;
   logic xlvl;
   logic src;
   logic ptick;
   logic tick;
   logic acc;
   logic wr;
   logic wr_cnt;
   logic [7:0] top;
   logic hit_a;
   logic hit_b;
   ett_flag_t set_v;
   ett_flag_t clr_v;
   logic [7:0] wd;

   // crystal level crosses via three flops
   ett_sync3 u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(crystal_pin_in_i),
      .lvl_o(xlvl)
   );

   // source is io clock unless crystal selected
   assign src = s_ff.asy ? (xlvl & ~s_ff.xprev) : 1'b1;

   ett_presc u_presc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .src_i(src),
      .cs_i(s_ff.cs),
      .tick_o(ptick)
   );

   // no tick when stopped or powered off
   assign tick = ptick & ~s_ff.pwr & (s_ff.cs != 3'h0);
   assign acc = cyc_i & stb_i & ~s_ff.ack;
   // write commits on the edge that sees ack
   assign wr = cyc_i & stb_i & s_ff.ack & we_i & sel_i[0];
   assign wr_cnt = wr & (adr_i == `ETT_OFS_CNT);
   assign wd = dat_i[7:0];
   // top is max or compare a
   assign top = (s_ff.wave == `ETT_WM_CTC || s_ff.wave == `ETT_WM_PCA ||
                 s_ff.wave == `ETT_WM_FASTA) ? s_ff.cmp_a : `ETT_MAX;
   // compare taken on each tick, blocked after a counter write
   assign hit_a = (s_ff.cnt == s_ff.cmp_a) & ~s_ff.block;
   assign hit_b = (s_ff.cnt == s_ff.cmp_b) & ~s_ff.block;

   always_comb begin
      nxt_s = s_ff;
      set_v = 3'h0;
      clr_v = svc_i;
      nxt_s.xprev = xlvl;
      nxt_s.xout = ~xlvl;
      nxt_s.ack = acc;
      nxt_s.match_a = 1'b0;
      nxt_s.match_b = 1'b0;
      if (tick) begin
         nxt_s.block = 1'b0;
         nxt_s.match_a = hit_a;
         nxt_s.match_b = hit_b;
         set_v[`ETT_FLG_CA] = hit_a;
         set_v[`ETT_FLG_CB] = hit_b;
         unique case (s_ff.wave)
            `ETT_WM_CTC: begin
               if (s_ff.cnt == top) begin
                  nxt_s.cnt = `ETT_BOTTOM;
               end else begin
                  nxt_s.cnt = s_ff.cnt + 8'h01;
               end
               // overflow only on wrap past max
               set_v[`ETT_FLG_OVF] = (s_ff.cnt == `ETT_MAX);
            end
            `ETT_WM_FASTMAX, `ETT_WM_FASTA: begin
               // overflow at top in fast modes
               if (s_ff.cnt == top) begin
                  nxt_s.cnt = `ETT_BOTTOM;
                  set_v[`ETT_FLG_OVF] = 1'b1;
               end else begin
                  nxt_s.cnt = s_ff.cnt + 8'h01;
               end
            end
            `ETT_WM_PCMAX, `ETT_WM_PCA: begin
               // overflow at bottom in dual slope
               if (!s_ff.down && s_ff.cnt == top) begin
                  nxt_s.down = 1'b1;
                  nxt_s.cnt = s_ff.cnt - 8'h01;
               end else if (s_ff.down && s_ff.cnt == `ETT_BOTTOM) begin
                  nxt_s.down = 1'b0;
                  nxt_s.cnt = s_ff.cnt + 8'h01;
                  set_v[`ETT_FLG_OVF] = 1'b1;
               end else if (s_ff.down) begin
                  nxt_s.cnt = s_ff.cnt - 8'h01;
               end else begin
                  nxt_s.cnt = s_ff.cnt + 8'h01;
               end
            end
            default: begin
               nxt_s.cnt = s_ff.cnt + 8'h01;
               nxt_s.down = 1'b0;
               set_v[`ETT_FLG_OVF] = (s_ff.cnt == `ETT_MAX);
            end
         endcase
      end
      if (wr) begin
         unique case (adr_i)
            `ETT_OFS_CNT: begin
               nxt_s.cnt = wd;
               nxt_s.block = 1'b1;
            end
            `ETT_OFS_CMPA: nxt_s.cmp_a = wd;
            `ETT_OFS_CMPB: nxt_s.cmp_b = wd;
            `ETT_OFS_CTLA: nxt_s.wave[1:0] = wd[1:0];
            `ETT_OFS_CTLB: begin
               nxt_s.wave[2] = wd[`ETT_WM2_BIT];
               nxt_s.cs = wd[2:0];
            end
            `ETT_OFS_FLG: clr_v = clr_v | wd[2:0];
            `ETT_OFS_MSK: nxt_s.msk = wd[2:0];
            `ETT_OFS_ASY: nxt_s.asy = wd[0];
            `ETT_OFS_PWR: nxt_s.pwr = wd[0];
            default: begin
            end
         endcase
      end
      // service or write-one clears, a set wins
      nxt_s.flg = (s_ff.flg & ~clr_v) | set_v;
      nxt_s.irq = |(nxt_s.flg & nxt_s.msk);
      // range ends seen by waveform side
      nxt_s.bottom = (nxt_s.cnt == `ETT_BOTTOM);
      nxt_s.top = (nxt_s.cnt == top);
      if (acc) begin
         unique case (adr_i)
            `ETT_OFS_CNT: nxt_s.dat = s_ff.cnt;
            `ETT_OFS_CMPA: nxt_s.dat = s_ff.cmp_a;
            `ETT_OFS_CMPB: nxt_s.dat = s_ff.cmp_b;
            `ETT_OFS_CTLA: nxt_s.dat = {6'h00, s_ff.wave[1:0]};
            `ETT_OFS_CTLB: nxt_s.dat = {4'h0, s_ff.wave[2], s_ff.cs};
            `ETT_OFS_FLG: nxt_s.dat = {5'h00, s_ff.flg};
            `ETT_OFS_MSK: nxt_s.dat = {5'h00, s_ff.msk};
            `ETT_OFS_ASY: nxt_s.dat = {7'h00, s_ff.asy};
            `ETT_OFS_PWR: nxt_s.dat = {7'h00, s_ff.pwr};
            default: nxt_s.dat = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_ff <= '0;
         s_ff.pwr <= `ETT_RST_PWR;
         s_ff.bottom <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign ack_o = s_ff.ack;
   assign dat_o = {24'h000000, s_ff.dat};
   assign irq_o = s_ff.irq;
   assign crystal_pin_out_o = s_ff.xout;
   assign match_a_o = s_ff.match_a;
   assign match_b_o = s_ff.match_b;
   assign top_o = s_ff.top;
   assign bottom_o = s_ff.bottom;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_bottom;
      bottom_o == (s_ff.cnt == 8'h00);
   endproperty
   a_bottom: assert property (p_bottom) else $error("bottom wrong");

   property p_stop;
      (s_ff.cs == 3'h0 && !wr) |=> $stable(s_ff.cnt);
   endproperty
   a_stop: assert property (p_stop) else $error("count while stopped");

   property p_pwr;
      (s_ff.pwr && !wr) |=> $stable(s_ff.cnt) && !match_a_o;
   endproperty
   a_pwr: assert property (p_pwr) else $error("active while off");

   property p_wrcnt;
      wr_cnt |=> s_ff.cnt == $past(dat_i[7:0]) && s_ff.block;
   endproperty
   a_wrcnt: assert property (p_wrcnt) else $error("write lost");

   property p_block;
      (s_ff.block && tick && !wr_cnt) |=> !match_a_o && !match_b_o && !s_ff.block;
   endproperty
   a_block: assert property (p_block) else $error("match not blocked");

   property p_norm;
      (tick && !wr && s_ff.wave == 3'h0 && s_ff.cnt == 8'hff)
         |=> s_ff.cnt == 8'h00 && s_ff.flg[0] && bottom_o;
   endproperty
   a_norm: assert property (p_norm) else $error("normal wrap");

   property p_ctc;
      (tick && !wr && s_ff.wave == 3'h2 && s_ff.cnt == s_ff.cmp_a)
         |=> s_ff.cnt == 8'h00;
   endproperty
   a_ctc: assert property (p_ctc) else $error("ctc clear");

   property p_up;
      (tick && !wr && s_ff.wave == 3'h0 && s_ff.cnt != 8'hff)
         |=> s_ff.cnt == $past(s_ff.cnt) + 8'h01;
   endproperty
   a_up: assert property (p_up) else $error("no increment");

   property p_cmpb;
      (tick && hit_b) |=> s_ff.flg[2] && match_b_o;
   endproperty
   a_cmpb: assert property (p_cmpb) else $error("compare b missed");

   property p_w1c;
      (wr && adr_i == 8'h14 && dat_i[1] && !(tick && hit_a)) |=> !s_ff.flg[1];
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag not cleared");

   property p_irq;
      irq_o == |(s_ff.flg & s_ff.msk);
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");

   // top level lags one cycle behind a config write
   property p_top;
      !$past(wr) |-> top_o == (s_ff.cnt == top);
   endproperty
   a_top: assert property (p_top) else $error("top wrong");

   property p_cmpa;
      (tick && hit_a) |=> s_ff.flg[1] && match_a_o;
   endproperty
   a_cmpa: assert property (p_cmpa) else $error("compare a missed");

   property p_fast;
      (tick && !wr && (s_ff.wave == 3'h3 || s_ff.wave == 3'h7) && s_ff.cnt == top)
         |=> s_ff.cnt == 8'h00 && s_ff.flg[0];
   endproperty
   a_fast: assert property (p_fast) else $error("fast top");

   property p_svc;
      (svc_i[1] && !(tick && hit_a)) |=> !s_ff.flg[1];
   endproperty
   a_svc: assert property (p_svc) else $error("service clear lost");

   c_ovf: cover property (tick && s_ff.wave == 3'h0 && s_ff.cnt == 8'hff);
   c_ctc: cover property (tick && s_ff.wave == 3'h2 && hit_a);
   c_irq: cover property ($rose(irq_o));
   c_blk: cover property (s_ff.block && tick && s_ff.cnt == s_ff.cmp_a);
   c_fast: cover property (tick && s_ff.wave == 3'h7 && s_ff.cnt == top);
endmodule

//--- dv/eight_bit_timer_counter_unit_test.sv
// self-checking bench of the eight-bit timer counter unit
// assumes ett_timer on a classic wishbone bus, one 50 ns clock
`timescale 1ns/1ps
`include "ett_consts.svh"
module eight_bit_timer_counter_unit_test;
   import ett_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [2:0] svc_i = 3'h0;
   logic xtal = 1'b0;
   logic ack_o, irq_o, xout, match_a_o, match_b_o, top_o, bottom_o;
   logic [31:0] dat_o;
   logic [31:0] rs = 32'h00006860;
   logic [31:0] exp_q[$];
   int n_fail = 0;
   int num_checks = 0;
   int n;
   ett_timer ett_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .ack_o(ack_o), .dat_o(dat_o), .svc_i(svc_i), .irq_o(irq_o),
      .crystal_pin_in_i(xtal), .crystal_pin_out_o(xout), .match_a_o(match_a_o),
      .match_b_o(match_b_o), .top_o(top_o), .bottom_o(bottom_o));
   always #25 clk_i = ~clk_i;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      // a read note never answered is a failure too
      if (exp_q.size() != 0)
         n_fail++;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // master holds the request until ack is sampled
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'h1;
      dat_i <= {24'h0, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(a, 1'b0, 8'h00);
   endtask
   // read data judged by the watcher, oldest note first
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0)
         chk(dat_o, exp_q.pop_front());
   end
   task automatic wait_m(output int c);
      c = 0;
      do begin
         @(posedge clk_i);
         c++;
      end while (match_a_o !== 1'b1);
   endtask
   // match period gives the count range of a mode
   task automatic per(input logic [7:0] la, input logic [7:0] lb, input int p);
      int c;
      wr(`ETT_OFS_CTLB, 8'h00);
      wr(`ETT_OFS_CTLA, la);
      wr(`ETT_OFS_CNT, 8'h00);
      wr(`ETT_OFS_CTLB, lb);
      wait_m(c);
      wait_m(c);
      chk(c, p);
      wr(`ETT_OFS_CTLB, 8'h00);
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      test_done();
   end
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // reset values, unmapped place reads zero
      for (int a = 0; a <= 36; a += 4)
         rd(a[7:0], (a == 32) ? 32'h1 : 32'h0);
      chk(bottom_o, 1'b1);
      chk(top_o, 1'b0);
      wr(`ETT_OFS_CTLB, 8'h01);
      repeat (20) @(posedge clk_i);
      rd(`ETT_OFS_CNT, 32'h0);
      wr(`ETT_OFS_CTLB, 8'h00);
      wr(`ETT_OFS_PWR, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rs = xs(rs);
         wr(`ETT_OFS_CNT, rs[7:0]);
         wr(`ETT_OFS_CMPA, rs[15:8]);
         wr(`ETT_OFS_CMPB, rs[23:16]);
         repeat (5) @(posedge clk_i);
         rd(`ETT_OFS_CNT, {24'h0, rs[7:0]});
         rd(`ETT_OFS_CMPA, {24'h0, rs[15:8]});
         rd(`ETT_OFS_CMPB, {24'h0, rs[23:16]});
      end
      // overflow at wrap, masked then unmasked
      wr(`ETT_OFS_CMPA, 8'h80);
      wr(`ETT_OFS_CMPB, 8'h80);
      wr(`ETT_OFS_FLG, 8'h07);
      wr(`ETT_OFS_CNT, 8'hff);
      chk(top_o, 1'b1);
      chk(bottom_o, 1'b0);
      wr(`ETT_OFS_CNT, 8'hf0);
      wr(`ETT_OFS_CTLB, 8'h01);
      repeat (40) @(posedge clk_i);
      wr(`ETT_OFS_CTLB, 8'h00);
      rd(`ETT_OFS_FLG, 32'h1);
      chk(irq_o, 1'b0);
      wr(`ETT_OFS_MSK, 8'h01);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b1);
      wr(`ETT_OFS_FLG, 8'h01);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b0);
      rd(`ETT_OFS_FLG, 32'h0);
      // ctc, fast to compare a, fast to max
      wr(`ETT_OFS_CMPA, 8'h10);
      per(8'h02, 8'h01, 17);
      per(8'h03, 8'h09, 17);
      per(8'h03, 8'h01, 256);
      // service pulse clears compare a flag
      wr(`ETT_OFS_MSK, 8'h02);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b1);
      svc_i <= 3'h2;
      @(posedge clk_i);
      svc_i <= 3'h0;
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b0);
      // write equal to compare b blocks the first match
      wr(`ETT_OFS_CTLA, 8'h00);
      wr(`ETT_OFS_CMPB, 8'h20);
      for (int i = 0; i < 2; i++) begin
         wr(`ETT_OFS_FLG, 8'h07);
         wr(`ETT_OFS_CNT, (i == 0) ? 8'h20 : 8'h1f);
         wr(`ETT_OFS_CTLB, 8'h01);
         repeat (6) @(posedge clk_i);
         wr(`ETT_OFS_CTLB, 8'h00);
         rd(`ETT_OFS_FLG, (i == 0) ? 32'h0 : 32'h4);
      end
      wr(`ETT_OFS_ASY, 8'h01);
      wr(`ETT_OFS_CNT, 8'h00);
      wr(`ETT_OFS_CTLB, 8'h01);
      repeat (10) @(posedge clk_i);
      chk(xout, 1'b1);
      for (int i = 0; i < 20; i++) begin
         xtal <= ~xtal;
         repeat (4) @(posedge clk_i);
      end
      repeat (10) @(posedge clk_i);
      wr(`ETT_OFS_CTLB, 8'h00);
      rd(`ETT_OFS_CNT, 32'h0a);
      repeat (3) @(posedge clk_i);
      test_done();
   end
endmodule
